// ==== pkg/jwr_pkg.sv ====
package jwr_pkg;

   // Clock rate
   localparam int unsigned CLK_HZ = 40_000_000;

   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_JUMPER     = 10'h1d2;
   localparam logic [9:0] IDX_RESPONSE   = 10'h1d3;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h1d4;
   localparam logic [9:0] IDX_IRQ_MASK   = 10'h1d5;
   localparam int unsigned ADDR_W        = 12;

   // Field positions
   localparam int unsigned JMP_ONE_BIT  = 1;
   localparam int unsigned JMP_TWO_BIT  = 0;
   localparam int unsigned FLAG_BIT     = 7;
   localparam int unsigned MODE_LSB     = 4;
   localparam int unsigned ALARM_BIT    = 3;
   localparam int unsigned EV_TIMEOUT   = 0;
   localparam int unsigned EV_JUMPER    = 1;
   localparam int unsigned EV_W         = 2;

   // Timeout action codes
   localparam logic [1:0] MODE_NONE = 2'h0;
   localparam logic [1:0] MODE_WARM = 2'h1;
   localparam logic [1:0] MODE_COLD = 2'h2;
   localparam logic [1:0] MODE_OFF  = 2'h3;

   // Timing
   localparam int unsigned WARM_PULSE_NS   = 1000;
   localparam int unsigned WARM_CYCLES     =
      (WARM_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned COLD_OFF_MS     = 4000;
   localparam int unsigned COLD_OFF_CYCLES = (CLK_HZ / 1000) * COLD_OFF_MS;
   localparam int unsigned CNT_W           = 28;

   // Synchroniser reset: pins idle, jumpers out
   localparam logic [3:0] PIN_RST = 4'hc;

   typedef enum logic [1:0] {JWR_IDLE, JWR_WARM, JWR_COLD, JWR_HALT} jwr_phase_t;

   // Board control outputs
   typedef struct packed {
      logic warm_reset;
      logic power_enable;
   } jwr_board_t;

   typedef struct packed {
      logic [1:0]      mode;
      logic [EV_W-1:0] irq_status;
      logic [EV_W-1:0] irq_mask;
      jwr_phase_t      phase;
      logic [CNT_W-1:0] count;
      logic [31:0]     prdata;
      logic            flag_prev;
      logic [1:0]      jump_prev;
      jwr_board_t      board;
   } jwr_state_t;

   localparam jwr_state_t STATE_RST = '{
      mode:       MODE_NONE,
      irq_status: '0,
      irq_mask:   '0,
      phase:      JWR_IDLE,
      count:      '0,
      prdata:     '0,
      flag_prev:  1'b1,           // Idle level of the flag, so no false edge
      jump_prev:  2'h0,
      board:      '{warm_reset: 1'b0, power_enable: 1'b1}
   };

endpackage

// ==== core/jwr_sync.sv ====
module jwr_sync #(
   parameter int unsigned W       = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         pclk,     // Clock
   input  wire logic         presetn,  // Async reset, low
   input  wire logic [W-1:0] raw,      // Pins from outside
   output logic      [W-1:0] stable    // Filtered levels
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] stable;
   } jwr_sync_st_t;

   jwr_sync_st_t st;
   jwr_sync_st_t next_st;

   if (W < 1)
   begin : g_bad_width
      $error("jwr_sync width must be at least one");
   end

   // Shift chain; a bit counts once stages two and three agree
   always_comb
   begin
      next_st    = st;
      next_st.s1 = raw;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < W; i++)
      begin
         if (st.s2[i] == st.s3[i])
         begin
            next_st.stable[i] = st.s3[i];
         end
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, stable: RST_VAL};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign stable = st.stable;
endmodule

// ==== core/jwr_regs.sv ====
// The implementer's own choice: the APB interface to the registers.
module jwr_regs
   import jwr_pkg::*;
#(
   parameter int unsigned COLD_OFF_CYCLES_P = jwr_pkg::COLD_OFF_CYCLES
) (
   input  wire logic                      pclk,                // 40 MHz clock
   input  wire logic                      presetn,             // Async reset, low
   input  wire logic                      psel,                // APB select
   input  wire logic                      penable,             // APB enable
   input  wire logic                      pwrite,              // APB direction
   input  wire logic [jwr_pkg::ADDR_W-1:0] paddr,              // APB byte address
   input  wire logic [31:0]               pwdata,              // APB write data
   output logic      [31:0]               prdata,              // APB read data
   output logic                           pready,              // APB ready
   output logic                           pslverr,             // APB error
   input  wire logic                      jumper_one_state,    // High when fitted
   input  wire logic                      jumper_two_state,    // High when fitted
   input  wire logic                      ext_timeout_flag_pin_n, // Low on timeout
   input  wire logic                      monitor_alarm_pin_n, // Low on alarm
   output jwr_pkg::jwr_board_t            board,               // Reset and power
   output logic                           irq                  // Level interrupt
);
   import jwr_pkg::*;

   localparam logic [ADDR_W-1:0] ADDR_JUMPER   = {IDX_JUMPER, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_RESPONSE = {IDX_RESPONSE, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_STATUS   = {IDX_IRQ_STATUS, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_MASK     = {IDX_IRQ_MASK, 2'h0};
   localparam logic [CNT_W-1:0]  WARM_LOAD     = CNT_W'(WARM_CYCLES - 1);
   localparam logic [CNT_W-1:0]  COLD_LOAD     = CNT_W'(COLD_OFF_CYCLES_P - 1);

   if (COLD_OFF_CYCLES_P < 1 || COLD_OFF_CYCLES_P > (1 << CNT_W))
   begin : g_bad_cold
      $error("COLD_OFF_CYCLES_P out of counter range");
   end

   jwr_state_t st;
   jwr_state_t next_st;
   logic [3:0] pins;
   logic       flag_n;
   logic       alarm_n;
   logic       jump_one;
   logic       jump_two;
   logic       flag_fall;
   logic       setup_rd;
   logic       access;
   logic       wr;
   logic       mapped;
   logic [7:0] rd_word;
   logic [EV_W-1:0] ev;

   // Filter all outside pins through three stages
   jwr_sync #(
      .W       (4),
      .RST_VAL (PIN_RST)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .raw     ({monitor_alarm_pin_n, ext_timeout_flag_pin_n,
                 jumper_one_state, jumper_two_state}),
      .stable  (pins)
   );

   assign alarm_n  = pins[3];
   assign flag_n   = pins[2];
   assign jump_one = pins[1];
   assign jump_two = pins[0];

   // Assertion edge of the flag, level ignored afterwards
   assign flag_fall = !flag_n && st.flag_prev;

   // Bus phases and decode
   assign setup_rd = psel && !penable && !pwrite;
   assign access   = psel && penable;
   assign wr       = access && pwrite && !pslverr;
   assign mapped   = (paddr == ADDR_JUMPER) || (paddr == ADDR_RESPONSE) ||
                     (paddr == ADDR_STATUS) || (paddr == ADDR_MASK);

   // Read word mux
   always_comb
   begin
      rd_word = 8'h00;
      unique case (paddr)
         ADDR_JUMPER:
         begin
            rd_word[JMP_ONE_BIT] = jump_one;
            rd_word[JMP_TWO_BIT] = jump_two;
         end
         ADDR_RESPONSE:
         begin
            rd_word[FLAG_BIT]                = !flag_n;
            rd_word[MODE_LSB+1:MODE_LSB]     = st.mode;
            rd_word[ALARM_BIT]               = !alarm_n;
         end
         ADDR_STATUS:
         begin
            rd_word[EV_W-1:0] = st.irq_status;
         end
         ADDR_MASK:
         begin
            rd_word[EV_W-1:0] = st.irq_mask;
         end
         default:
         begin
            rd_word = 8'h00;
         end
      endcase
   end

   // Events: flag assertion and any jumper change
   always_comb
   begin
      ev             = '0;
      ev[EV_TIMEOUT] = flag_fall;
      ev[EV_JUMPER]  = {jump_one, jump_two} != st.jump_prev;
   end

   // Next state: registers, interrupt bits and timeout action
   always_comb
   begin
      next_st           = st;
      next_st.flag_prev = flag_n;
      next_st.jump_prev = {jump_one, jump_two};
      if (setup_rd)
      begin
         next_st.prdata = {24'h000000, rd_word};
      end
      // Jumper address is read-only, writes fall through
      if (wr && paddr == ADDR_RESPONSE)
      begin
         next_st.mode = pwdata[MODE_LSB+1:MODE_LSB];
      end
      if (wr && paddr == ADDR_MASK)
      begin
         next_st.irq_mask = pwdata[EV_W-1:0];
      end
      // Write one clears; a new event wins over the clear
      if (wr && paddr == ADDR_STATUS)
      begin
         next_st.irq_status = st.irq_status & ~pwdata[EV_W-1:0];
      end
      next_st.irq_status = next_st.irq_status | ev;
      unique case (st.phase)
         JWR_IDLE:
         begin
            if (flag_fall)
            begin
               unique case (st.mode)
                  MODE_NONE:
                  begin
                     next_st.phase = JWR_IDLE;
                  end
                  MODE_WARM:
                  begin
                     next_st.phase            = JWR_WARM;
                     next_st.count            = WARM_LOAD;
                     next_st.board.warm_reset = 1'b1;
                  end
                  MODE_COLD:
                  begin
                     next_st.phase              = JWR_COLD;
                     next_st.count              = COLD_LOAD;
                     next_st.board.power_enable = 1'b0;
                  end
                  MODE_OFF:
                  begin
                     next_st.phase              = JWR_HALT;
                     next_st.board.power_enable = 1'b0;
                  end
               endcase
            end
         end
         JWR_WARM:
         begin
            if (st.count == '0)
            begin
               next_st.phase            = JWR_IDLE;
               next_st.board.warm_reset = 1'b0;
            end
            else
            begin
               next_st.count = st.count - 1'b1;
            end
         end
         JWR_COLD:
         begin
            if (st.count == '0)
            begin
               next_st.phase              = JWR_IDLE;
               next_st.board.power_enable = 1'b1;
            end
            else
            begin
               next_st.count = st.count - 1'b1;
            end
         end
         JWR_HALT:
         begin
            next_st.phase = JWR_HALT;
         end
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st <= STATE_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs
   assign prdata  = st.prdata;
   assign pready  = 1'b1;
   assign pslverr = access && !mapped;
   assign board   = st.board;
   assign irq     = |(st.irq_status & st.irq_mask);

   // Read of an address in its access cycle
   sequence s_read(logic [ADDR_W-1:0] a);
      access && !pwrite && paddr == a && $past(setup_rd);
   endsequence

   // A detected timeout with a given code, from idle
   sequence s_trigger(logic [1:0] code);
      st.phase == JWR_IDLE && flag_fall && st.mode == code;
   endsequence

   jumper_one_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_read(ADDR_JUMPER) |-> prdata[JMP_ONE_BIT] == $past(jump_one))
      else $error("jumper one bit wrong");

   jumper_two_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_read(ADDR_JUMPER) |-> prdata[JMP_TWO_BIT] == $past(jump_two))
      else $error("jumper two bit wrong");

   jumper_upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_read(ADDR_JUMPER) |-> prdata[7:2] == 6'h00)
      else $error("jumper upper bits not zero");

   jumper_write_inert_a: assert property (@(posedge pclk) disable iff (!presetn)
      access && pwrite && paddr == ADDR_JUMPER |-> !pslverr ##1 $stable(st.mode))
      else $error("jumper write had an effect");

   flag_state_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_read(ADDR_RESPONSE) |-> prdata[FLAG_BIT] == !$past(flag_n))
      else $error("flag state bit not inverted pin");

   mode_none_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_trigger(MODE_NONE) |=> st.phase == JWR_IDLE && board.power_enable
         && !board.warm_reset)
      else $error("mode 00 took an action");

   edge_only_a: assert property (@(posedge pclk) disable iff (!presetn)
      st.phase == JWR_IDLE && !flag_fall |=> st.phase == JWR_IDLE)
      else $error("action without flag assertion");

   warm_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_trigger(MODE_WARM) |=> (board.warm_reset && board.power_enable)[*8])
      else $error("warm reset pulse wrong");

   cold_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_trigger(MODE_COLD) |=> (!board.power_enable)[*8])
      else $error("cold reset did not remove power");

   cold_restore_a: assert property (@(posedge pclk) disable iff (!presetn)
      st.phase == JWR_COLD && st.count == '0 |=> board.power_enable
         && st.phase == JWR_IDLE)
      else $error("cold reset did not restore power");

   halt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      st.phase == JWR_HALT |=> st.phase == JWR_HALT && !board.power_enable)
      else $error("power restored after shutdown");

   code_map_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_trigger(MODE_OFF) |=> st.phase == JWR_HALT ##1 !board.power_enable)
      else $error("mode 11 not mapped to power off");
endmodule

// ==== testbench/jwr_pins.sv ====
module jwr_pins (
   input  wire logic fit_one,                // Jumper one fitted
   input  wire logic fit_two,                // Jumper two fitted
   input  wire logic timeout,                // Watchdog timeout raised
   input  wire logic alarm,                  // Monitor alarm raised
   output logic      jumper_one_state,       // Jumper one pin
   output logic      jumper_two_state,       // Jumper two pin
   output logic      ext_timeout_flag_pin_n, // Watchdog flag, low active
   output logic      monitor_alarm_pin_n     // Monitor alarm, low active
);
   timeunit 1ns;
   timeprecision 100ps;

   // Jumpers read high when fitted; flag lines idle high and pull low on events
   assign jumper_one_state       = fit_one;
   assign jumper_two_state       = fit_two;
   assign ext_timeout_flag_pin_n = ~timeout;
   assign monitor_alarm_pin_n    = ~alarm;
endmodule

// ==== testbench/testbench.sv ====
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import jwr_pkg::*;

   localparam int          COLD  = 20;
   localparam int          LAT   = 4;  // Watch samples before an action reaches the board
   localparam logic [11:0] A_JMP = {IDX_JUMPER, 2'h0};
   localparam logic [11:0] A_RSP = {IDX_RESPONSE, 2'h0};
   localparam logic [11:0] A_STS = {IDX_IRQ_STATUS, 2'h0};
   localparam logic [11:0] A_MSK = {IDX_IRQ_MASK, 2'h0};

   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   jwr_board_t  board;
   logic        fit1    = 1'b0;
   logic        fit2    = 1'b0;
   logic        tmo     = 1'b0;
   logic        alm     = 1'b0;
   logic        j1, j2, flag_n, alarm_n;
   logic [31:0] seed    = 32'd69678;
   logic [31:0] rd;
   logic        err;
   int          miscompares = 0;
   int          n_tests     = 0;
   int          wcnt, pcnt;

   // 25 ns clock
   always #12.5 pclk = ~pclk;

   jwr_pins pins (.fit_one(fit1), .fit_two(fit2), .timeout(tmo), .alarm(alm),
      .jumper_one_state(j1), .jumper_two_state(j2),
      .ext_timeout_flag_pin_n(flag_n), .monitor_alarm_pin_n(alarm_n));

   jwr_regs #(.COLD_OFF_CYCLES_P(COLD)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .jumper_one_state(j1), .jumper_two_state(j2),
      .ext_timeout_flag_pin_n(flag_n), .monitor_alarm_pin_n(alarm_n),
      .board(board), .irq(irq));

   // Random source, fixed start
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected response register image
   function automatic logic [31:0] exp_resp(input logic [1:0] m, input logic fl,
                                            input logic al);
      return {24'h0, fl, 1'b0, m, al, 3'h0};
   endfunction

   // Final verdict
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer, held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      rd  = prdata;
      err = pslverr;
      if (n >= 16)
      begin
         miscompares++;
         close_out();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask

   task automatic settle;
      @(posedge pclk);
      #1;
   endtask

   // Count warm reset and power-off cycles over a fixed span
   task automatic watch;
      wcnt = 0;
      pcnt = 0;
      repeat (300)
      begin
         settle();
         wcnt += (board.warm_reset === 1'b1);
         pcnt += (board.power_enable === 1'b0);
      end
   endtask

   task automatic do_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   // Main sequence
   initial
   begin
      do_reset();
      rd_chk(A_JMP, 32'h0, "jumper reset");
      rd_chk(A_RSP, 32'h0, "response reset");
      // Random jumper, alarm and write data; jumper writes must not stick
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         fit1 <= seed[0];
         fit2 <= seed[1];
         alm  <= seed[2];
         repeat (8) @(posedge pclk);
         apb(1'b1, A_JMP, seed);
         rd_chk(A_JMP, {30'h0, seed[0], seed[1]}, "jumper");
         apb(1'b1, A_RSP, seed);
         rd_chk(A_RSP, exp_resp(seed[5:4], 1'b0, seed[2]), "response");
      end
      // Every timeout action, flag held low throughout the span
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, A_RSP, {26'h0, m[1:0], 4'h0});
         tmo <= 1'b1;
         watch();
         rd_chk(A_RSP, exp_resp(m[1:0], 1'b1, alm), "flag low");
         chk("warm cycles", (m == 1) ? WARM_CYCLES : 0, wcnt);
         chk("power off cycles", (m == 2) ? COLD : (m == 3) ? 300 - LAT : 0, pcnt);
         tmo <= 1'b0;
         repeat (8) @(posedge pclk);
      end
      // Jumper one fitted across reset, so its filtered rise is a change event
      fit1 <= 1'b1;
      fit2 <= 1'b0;
      do_reset();
      // Interrupt: sticky, masked, cleared by writing one
      tmo <= 1'b1;
      settle();
      chk("board after reset", 32'h1, {30'h0, board});
      repeat (8) @(posedge pclk);
      rd_chk(A_STS, 32'h3, "status");
      settle();
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, A_MSK, 32'h1);
      settle();
      chk("irq on", 32'h1, {31'h0, irq});
      apb(1'b1, A_STS, 32'h1);
      settle();
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd_chk(A_STS, 32'h2, "status cleared");
      apb(1'b1, A_STS, 32'h2);
      rd_chk(A_STS, 32'h0, "status all clear");
      tmo <= 1'b0;
      // Unmapped address
      apb(1'b0, 12'h700, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      chk("unmapped read", 32'h0, rd);
      close_out();
   end
endmodule
